/* design/timer_core_pkg.sv */
// Package for the timer counter core: register map, field layout,
// reset values, clock source codes and the bus request bundle.
// Assumes a 32-bit Avalon-MM master with byte addresses.
package timer_core_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses, one byte register per word)
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_COUNT_HIGH = 5'h04;
    localparam logic [4:0] ADDR_COUNT_LOW = 5'h08;
    localparam logic [4:0] ADDR_LIMIT_HIGH = 5'h0c;
    localparam logic [4:0] ADDR_LIMIT_LOW = 5'h10;

    // ------------------------------------------------------------
    // Status/control field positions
    // ------------------------------------------------------------
    localparam int WRAP_FLAG_BIT = 7;
    localparam int IRQ_ENABLE_BIT = 6;
    localparam int CENTER_BIT = 5;
    localparam int CLK_SEL_HI_BIT = 4;
    localparam int CLK_SEL_LO_BIT = 3;
    localparam int PRESCALE_MSB = 2;

    // ------------------------------------------------------------
    // Reset values and counter constants
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_FULL = 16'hffff;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [6:0] PRESCALE_RESET = 7'h00;
    localparam logic [31:0] READ_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_BUS = 2'b01,
        SRC_FIXED = 2'b10,
        SRC_EXT = 2'b11
    } clock_source_e;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_DONE = 1'b1
    } bus_state_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avalon_req_s;
endpackage : timer_core_pkg

/* design/timer_counter_control_core.sv */
// Timer counter core: status/control, 16-bit counter with coherent
// byte reads, 16-bit wrap limit with write inhibit, clock select and
// prescaler. Assumes an Avalon-MM master on CLK and a debug freeze
// level produced by logic on the same clock.
`timescale 1ns/100ps

module timer_counter_control_core (
    input wire logic CLK, // Bus clock, 25 MHz
    input wire logic RST, // Synchronous reset, active high
    input timer_core_pkg::avalon_req_s AVS_REQ, // Avalon request bundle
    output logic [31:0] AVS_READDATA, // Read data, byte in low lane
    output logic AVS_WAITREQUEST, // Low for one cycle to answer
    input wire logic EXT_TIMER_CLK, // External timer clock pin
    input wire logic FIXED_CLK, // Fixed system clock level
    input wire logic DEBUG_FREEZE, // Background debug active
    output logic WRAP_IRQ, // Wrap interrupt request
    output logic [15:0] COUNT_VALUE, // Counter value to channels
    output logic COUNT_DOWN, // Counting down in center mode
    output logic CENTER_ALIGN // Center-aligned select to channels
);
    import timer_core_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bus_state_e bus_state_reg;
    clock_source_e clk_sel_reg;
    logic [31:0] readdata_reg;
    logic [15:0] count_reg, count_next, limit_reg, buffer_reg, top, shown;
    logic [7:0] rd_value;
    logic [6:0] pre_cnt_reg;
    logic [2:0] prescale_reg;
    logic waitreq_reg, flag_reg, armed_reg, irq_en_reg, center_reg, irq_reg;
    logic down_reg, down_next, latched_reg, wait_high_reg;
    logic limit_hi_written_reg, limit_lo_written_reg;
    logic ext_sync1_reg, ext_sync2_reg, ext_prev_reg;
    logic fix_sync1_reg, fix_sync2_reg, fix_prev_reg;
    logic accept, rd_sc, wr_sc, rd_ch, rd_cl, wr_cnt, wr_lh, wr_ll;
    logic src_pulse, tick, wrap_event, wrap_set, inhibit;

    // Mask of low prescaler bits that must all be set for a tick
    function automatic logic [6:0] prescale_mask(input logic [2:0] ps);
        prescale_mask = 7'((8'h01 << ps) - 8'h01);
    endfunction : prescale_mask

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Effects happen once, at the edge that accepts the request
    assign accept = (AVS_REQ.read || AVS_REQ.write) && (bus_state_reg == BUS_IDLE);

    function automatic logic hit_wr(input avalon_req_s r, input logic [4:0] a);
        hit_wr = r.write && r.byteenable[0] && (r.address == a);
    endfunction : hit_wr

    assign rd_sc = accept && AVS_REQ.read && (AVS_REQ.address == ADDR_STATUS_CONTROL);
    assign rd_ch = accept && AVS_REQ.read && (AVS_REQ.address == ADDR_COUNT_HIGH);
    assign rd_cl = accept && AVS_REQ.read && (AVS_REQ.address == ADDR_COUNT_LOW);
    assign wr_sc = accept && hit_wr(AVS_REQ, ADDR_STATUS_CONTROL);
    assign wr_cnt = accept && (hit_wr(AVS_REQ, ADDR_COUNT_HIGH)
                    || hit_wr(AVS_REQ, ADDR_COUNT_LOW));
    assign wr_lh = accept && hit_wr(AVS_REQ, ADDR_LIMIT_HIGH);
    assign wr_ll = accept && hit_wr(AVS_REQ, ADDR_LIMIT_LOW);

    always_ff @(posedge CLK) begin
        if (RST) begin
            bus_state_reg <= BUS_IDLE;
            waitreq_reg <= 1'b1;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (accept) begin
                        bus_state_reg <= BUS_DONE;
                        waitreq_reg <= 1'b0;
                    end
                end
                BUS_DONE: begin
                    bus_state_reg <= BUS_IDLE;
                    waitreq_reg <= 1'b1;
                end
                default: begin
                    bus_state_reg <= BUS_IDLE;
                    waitreq_reg <= 1'b1;
                end
            endcase
        end
    end

    assign shown = latched_reg ? buffer_reg : count_reg;

    always_comb begin
        case (AVS_REQ.address)
            ADDR_STATUS_CONTROL: rd_value = {flag_reg, irq_en_reg, center_reg,
                                             clk_sel_reg, prescale_reg};
            ADDR_COUNT_HIGH: rd_value = shown[15:8];
            ADDR_COUNT_LOW: rd_value = shown[7:0];
            ADDR_LIMIT_HIGH: rd_value = limit_reg[15:8];
            ADDR_LIMIT_LOW: rd_value = limit_reg[7:0];
            default: rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            readdata_reg <= READ_RESET;
        end else if (accept && AVS_REQ.read) begin
            readdata_reg <= {24'h000000, rd_value};
        end
    end

    // ------------------------------------------------------------
    // Status and control
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_en_reg <= STATUS_RESET[IRQ_ENABLE_BIT];
            center_reg <= STATUS_RESET[CENTER_BIT];
            clk_sel_reg <= SRC_NONE;
            prescale_reg <= STATUS_RESET[PRESCALE_MSB:0];
        end else if (wr_sc) begin
            irq_en_reg <= AVS_REQ.writedata[IRQ_ENABLE_BIT];
            center_reg <= AVS_REQ.writedata[CENTER_BIT];
            clk_sel_reg <= clock_source_e'(AVS_REQ.writedata[CLK_SEL_HI_BIT:CLK_SEL_LO_BIT]);
            prescale_reg <= AVS_REQ.writedata[PRESCALE_MSB:0];
        end
    end

    // A new wrap beats a pending clear and restarts the sequence
    always_ff @(posedge CLK) begin
        if (RST) begin
            flag_reg <= STATUS_RESET[WRAP_FLAG_BIT];
            armed_reg <= 1'b0;
        end else if (wrap_set) begin
            flag_reg <= 1'b1;
            armed_reg <= 1'b0;
        end else if (wr_sc) begin
            if (armed_reg && !AVS_REQ.writedata[WRAP_FLAG_BIT]) begin
                flag_reg <= 1'b0;
            end
            armed_reg <= 1'b0;
        end else if (rd_sc && flag_reg) begin
            armed_reg <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= flag_reg && irq_en_reg;
        end
    end

    // ------------------------------------------------------------
    // Clock synchronizers and prescaler
    // ------------------------------------------------------------
    // two stages, then edge detect
    always_ff @(posedge CLK) begin
        if (RST) begin
            ext_sync1_reg <= 1'b0;
            ext_sync2_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
            fix_sync1_reg <= 1'b0;
            fix_sync2_reg <= 1'b0;
            fix_prev_reg <= 1'b0;
        end else begin
            ext_sync1_reg <= EXT_TIMER_CLK;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg <= ext_sync2_reg;
            fix_sync1_reg <= FIXED_CLK;
            fix_sync2_reg <= fix_sync1_reg;
            fix_prev_reg <= fix_sync2_reg;
        end
    end

    // source select; bounds the pin rate
    always_comb begin
        case (clk_sel_reg)
            SRC_BUS: src_pulse = 1'b1;
            SRC_FIXED: src_pulse = fix_sync2_reg && !fix_prev_reg;
            SRC_EXT: src_pulse = ext_sync2_reg && !ext_prev_reg;
            default: src_pulse = 1'b0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pre_cnt_reg <= PRESCALE_RESET;
        end else if (src_pulse && !DEBUG_FREEZE) begin
            pre_cnt_reg <= 7'(pre_cnt_reg + 7'h01);
        end
    end

    assign tick = src_pulse && !DEBUG_FREEZE
                  && ((pre_cnt_reg & prescale_mask(prescale_reg)) == prescale_mask(prescale_reg));

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // zero and all ones both give full range
    assign top = (limit_reg == LIMIT_RESET) ? COUNT_FULL : limit_reg;

    always_comb begin
        count_next = count_reg;
        down_next = down_reg;
        wrap_event = 1'b0;
        if (wr_cnt) begin
            count_next = COUNT_RESET;
            down_next = 1'b0;
        end else if (tick) begin
            if (!center_reg) begin
                down_next = 1'b0;
                if (count_reg == top) begin
                    count_next = COUNT_RESET;
                    wrap_event = 1'b1;
                end else begin
                    count_next = 16'(count_reg + COUNT_ONE);
                end
            end else if (down_reg) begin
                if (count_reg == COUNT_RESET) begin
                    down_next = 1'b0;
                    count_next = COUNT_ONE;
                end else begin
                    count_next = 16'(count_reg - COUNT_ONE);
                end
            end else if (count_reg == top) begin
                // step below limit sets flag; turn
                down_next = 1'b1;
                count_next = 16'(count_reg - COUNT_ONE);
                wrap_event = 1'b1;
            end else begin
                count_next = 16'(count_reg + COUNT_ONE);
            end
        end
    end

    assign inhibit = limit_hi_written_reg || limit_lo_written_reg;
    assign wrap_set = wrap_event && !inhibit;

    // reset clears; no tick while frozen
    always_ff @(posedge CLK) begin
        if (RST) begin
            count_reg <= COUNT_RESET;
            down_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            down_reg <= down_next;
        end
    end

    // ------------------------------------------------------------
    // Wrap limit
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            limit_reg <= LIMIT_RESET;
            limit_hi_written_reg <= 1'b0;
            limit_lo_written_reg <= 1'b0;
        end else begin
            if (wr_lh) begin
                limit_reg[15:8] <= AVS_REQ.writedata[7:0];
                limit_hi_written_reg <= !limit_lo_written_reg;
                limit_lo_written_reg <= 1'b0;
            end else if (wr_ll) begin
                limit_reg[7:0] <= AVS_REQ.writedata[7:0];
                limit_lo_written_reg <= !limit_hi_written_reg;
                limit_hi_written_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Coherent read buffer
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            latched_reg <= 1'b0;
            wait_high_reg <= 1'b0;
            buffer_reg <= COUNT_RESET;
        end else if (wr_cnt || wr_sc) begin
            latched_reg <= 1'b0;
        end else if (!DEBUG_FREEZE && (rd_ch || rd_cl)) begin
            if (!latched_reg) begin
                latched_reg <= 1'b1;
                buffer_reg <= count_reg;
                wait_high_reg <= rd_cl;
            end else if ((rd_ch && wait_high_reg) || (rd_cl && !wait_high_reg)) begin
                latched_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign AVS_READDATA = readdata_reg;
    assign AVS_WAITREQUEST = waitreq_reg;
    assign WRAP_IRQ = irq_reg;
    assign COUNT_VALUE = count_reg;
    assign COUNT_DOWN = down_reg;
    assign CENTER_ALIGN = center_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_up_wrap_flag: assert property (
        tick && !center_reg && !wr_cnt && count_reg == top && !inhibit
        |=> flag_reg && count_reg == 16'h0000)
        else $error("up wrap did not set flag");
    a_center_turn: assert property (
        tick && center_reg && !down_reg && !wr_cnt && count_reg == top && !inhibit
        |=> flag_reg && down_reg && count_reg == $past(count_reg) - 16'h0001)
        else $error("center turn wrong");
    a_clear_seq: assert property (
        $fell(flag_reg) |-> $past(armed_reg) && $past(wr_sc)
        && !$past(AVS_REQ.writedata[7]))
        else $error("flag cleared outside sequence");
    a_set_wins: assert property (
        wrap_set && wr_sc |=> flag_reg && !armed_reg)
        else $error("wrap lost against clear");
    a_write_one: assert property (
        wr_sc && AVS_REQ.writedata[7] && flag_reg |=> flag_reg)
        else $error("writing one changed flag");
    a_irq_follow: assert property (
        ##1 WRAP_IRQ == ($past(flag_reg) && $past(irq_en_reg)))
        else $error("irq mismatch");
    a_idle_hold: assert property (
        clk_sel_reg == SRC_NONE && !wr_cnt |=> $stable(count_reg))
        else $error("counter moved with no source");
    a_prescale_gap: assert property (
        tick && prescale_reg == 3'h1 && $past(prescale_reg) == 3'h1 |-> !$past(tick))
        else $error("prescale by two ticked twice");
    a_freeze_hold: assert property (
        DEBUG_FREEZE && !wr_cnt && !wr_sc
        |=> $stable(count_reg) && $stable(latched_reg))
        else $error("freeze did not hold");
    a_buffer_stable: assert property (
        latched_reg && $past(latched_reg) |-> $stable(buffer_reg))
        else $error("latched buffer changed");
    a_count_clear: assert property (
        wr_cnt |=> count_reg == 16'h0000 && !latched_reg)
        else $error("counter write did not clear");
    a_limit_inhibit: assert property (
        wr_lh && !limit_lo_written_reg |=> inhibit)
        else $error("limit inhibit not armed");
    a_wrap_inhibit: assert property (wrap_event && inhibit && !flag_reg |=> !flag_reg)
        else $error("inhibited wrap set flag");
    a_bus_answer: assert property (
        accept |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer timing");

    c_up_wrap: cover property (wrap_set && !center_reg);
    c_center_turn: cover property (wrap_set && center_reg);
    c_flag_clear: cover property ($fell(flag_reg));
    c_coherent_pair: cover property (rd_cl && !latched_reg ##[1:20] rd_ch && latched_reg);
endmodule : timer_counter_control_core

/* sim/timer_counter_control_core_tb.sv */
// Self-checking bench for the timer counter core.
// Assumes the core answers each bus access one cycle after taking it.
`timescale 1ns/100ps
module timer_counter_control_core_tb;
    import timer_core_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    avalon_req_s req = '0;
    logic [31:0] rdata;
    logic wait_req, irq, down, center;
    logic [15:0] cnt, base;
    logic ext_clk = 1'b0;
    logic fix_clk = 1'b0;
    logic freeze = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] rnd;
    clock_source_e srcs[3] = '{SRC_EXT, SRC_FIXED, SRC_NONE};
    int bad_count = 0;
    int n_checks = 0;
    int n;

    always #20 CLK = ~CLK;

    timer_counter_control_core i_dut (.CLK(CLK), .RST(RST), .AVS_REQ(req),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .EXT_TIMER_CLK(ext_clk),
        .FIXED_CLK(fix_clk), .DEBUG_FREEZE(freeze), .WRAP_IRQ(irq),
        .COUNT_VALUE(cnt), .COUNT_DOWN(down), .CENTER_ALIGN(center));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    // Read data is judged against the oldest note at the answer edge
    always @(posedge CLK) begin
        if (wait_req === 1'b0 && req.read === 1'b1 && exp_q.size() > 0) begin
            check("read data", rdata, exp_q.pop_front());
        end
    end

    task automatic bus(input logic rd, input logic [4:0] addr, input logic [7:0] data,
        input logic [7:0] want);
        int k;
        k = 0;
        @(posedge CLK);
        if (rd) exp_q.push_back({24'h0, want});
        req <= '{read: rd, write: !rd, address: addr, writedata: {24'h0, data},
            byteenable: 4'hf};
        do begin
            @(posedge CLK);
            k++;
        end while (wait_req !== 1'b0 && k < 50);
        if (k >= 50) check("bus answer", 32'h1, 32'h0);
        req <= '0;
    endtask : bus

    task automatic rd(input logic [4:0] addr, input logic [7:0] want);
        bus(1'b1, addr, 8'h00, want);
    endtask : rd

    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        bus(1'b0, addr, data, 8'h00);
    endtask : wr

    // quarter bus rate
    // Pin edges at a quarter of the bus rate, then time for the synchronizer
    task automatic pulses(input int cnt_n, input logic fixed);
        repeat (cnt_n) begin
            @(posedge CLK);
            if (fixed) fix_clk <= 1'b1;
            else ext_clk <= 1'b1;
            repeat (2) @(posedge CLK);
            fix_clk <= 1'b0;
            ext_clk <= 1'b0;
            @(posedge CLK);
        end
        repeat (5) @(posedge CLK);
    endtask : pulses

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge CLK);
        bad_count++;
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(51));
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        rd(ADDR_STATUS_CONTROL, 8'h00);
        rd(ADDR_COUNT_HIGH, 8'h00);
        rd(ADDR_COUNT_LOW, 8'h00);
        rd(ADDR_LIMIT_HIGH, 8'h00);
        rd(ADDR_LIMIT_LOW, 8'h00);
        rd(5'h14, 8'h00);
        check("center", {31'h0, center}, 32'h0);
        $display("test reset done");
        // Step size over a whole prescale window is exact whatever the phase
        // no channel pin shared
        for (int s = 0; s < 3; s++) begin
            for (int p = 0; p < 3; p++) begin
                wr(ADDR_STATUS_CONTROL, {3'h0, srcs[s], p[2:0]});
                base = cnt;
                pulses(4 << p, srcs[s] == SRC_FIXED);
                check("count step", {16'h0, cnt - base}, (srcs[s] == SRC_NONE) ? 0 : 4);
            end
        end
        wr(ADDR_STATUS_CONTROL, 8'h18);
        freeze <= 1'b1;
        base = cnt;
        pulses(3, 1'b0);
        check("frozen count", {16'h0, cnt}, {16'h0, base});
        freeze <= 1'b0;
        $display("test sources done");
        rnd = $urandom();
        wr(ADDR_COUNT_HIGH, rnd[7:0]);
        rd(ADDR_COUNT_LOW, 8'h00);
        rd(ADDR_COUNT_HIGH, 8'h00);
        pulses(3, 1'b0);
        rd(ADDR_COUNT_HIGH, 8'h00);
        pulses(2, 1'b0);
        rd(ADDR_COUNT_LOW, 8'h03);
        rd(ADDR_COUNT_LOW, 8'h05);
        rd(ADDR_COUNT_HIGH, 8'h00);
        $display("test coherent read done");
        rnd = $urandom();
        wr(ADDR_COUNT_LOW, rnd[7:0]);
        wr(ADDR_LIMIT_LOW, 8'h02);
        wr(ADDR_LIMIT_HIGH, 8'h00);
        wr(ADDR_LIMIT_HIGH, 8'h00);
        pulses(4, 1'b0);
        rd(ADDR_STATUS_CONTROL, 8'h18);
        wr(ADDR_LIMIT_LOW, 8'h02);
        pulses(3, 1'b0);
        rd(ADDR_STATUS_CONTROL, 8'h98);
        pulses(3, 1'b0);
        wr(ADDR_STATUS_CONTROL, 8'h18);
        rd(ADDR_STATUS_CONTROL, 8'h98);
        $display("test wrap done");
        wr(ADDR_STATUS_CONTROL, 8'h38);
        wr(ADDR_COUNT_HIGH, 8'h00);
        pulses(3, 1'b0);
        check("down", {31'h0, down}, 32'h1);
        check("center", {31'h0, center}, 32'h1);
        check("irq off", {31'h0, irq}, 32'h0);
        rd(ADDR_STATUS_CONTROL, 8'hb8);
        wr(ADDR_STATUS_CONTROL, 8'hf8);
        repeat (2) @(posedge CLK);
        check("irq on", {31'h0, irq}, 32'h1);
        pulses(2, 1'b0);
        check("up again", {15'h0, down, cnt}, 32'h1);
        $display("test center done");
        rd(ADDR_STATUS_CONTROL, 8'hf8);
        wr(ADDR_STATUS_CONTROL, 8'h00);
        rd(ADDR_STATUS_CONTROL, 8'h00);
        wr(ADDR_LIMIT_HIGH, 8'h00);
        wr(ADDR_LIMIT_LOW, 8'h01);
        wr(ADDR_STATUS_CONTROL, 8'h4f);
        n = 0;
        while (irq !== 1'b1 && n < 800) begin
            @(posedge CLK);
            n++;
        end
        check("bus wrap irq", {31'h0, irq}, 32'h1);
        wr(ADDR_STATUS_CONTROL, 8'hcf);
        rd(ADDR_STATUS_CONTROL, 8'hcf);
        wr(ADDR_STATUS_CONTROL, 8'h4f);
        rd(ADDR_STATUS_CONTROL, 8'h4f);
        check("irq cleared", {31'h0, irq}, 32'h0);
        $display("test bus clock done");
        test_done();
    end
endmodule : timer_counter_control_core_tb
